// >>> hw/bfmr_dev.sv
// queue-pair device: two queues, flags, mailboxes, retransmit, port b lanes
// Notes on behaviour
// - port b almost-empty rises next cycle after write
// - port a almost-empty rises next cycle after write
// - port a almost-full rises next cycle after read
// - port b almost-full rises next cycle after read
// - narrow b: almost-empty drops on final lane read
// - narrow b: almost-full drops on final lane write
// - narrow b: a almost-empty timed from final lane
// - narrow b: a almost-full timed from final lane
// - a-to-b queue select codes on both ports
// - b-to-a queue select codes, all low
// - word size: a-to-b mail keeps bits 0-17
// - byte size: a-to-b mail keeps bits 0-8
// - word size: b-to-a mail keeps bits 0-17
// - byte size: b-to-a mail keeps bits 0-8
// - standard mode: empty flag high ends setup
// - fall-through: output valid high ends setup
// - writer keeps at most depth-2 before retransmit
// - retransmit restarts at first word after reset
// - depth is one of three densities
`timescale 1ns/1ps
`default_nettype none
module bfmr_dev
  import bfmr_pkg::*;
#(
  parameter int DEPTH      = BFMR_DEPTH_16K,
  parameter int ALMOST_OFS = BFMR_ALMOST_OFS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  bfmr_if.dev      bus
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C   = CW'(DEPTH);
  localparam logic [CW-1:0] AE_C      = CW'(ALMOST_OFS);
  localparam logic [CW-1:0] AF_STD_C  = CW'(DEPTH - ALMOST_OFS);
  localparam logic [CW-1:0] AF_FT_C   = CW'(DEPTH + 1 - ALMOST_OFS);

  if (!(DEPTH == BFMR_DEPTH_16K || DEPTH == BFMR_DEPTH_32K || DEPTH == BFMR_DEPTH_64K))
  begin : g_bad_depth
    $error("depth must be one of the three densities");
  end
  if (ALMOST_OFS < 1 || ALMOST_OFS >= DEPTH / 2) begin : g_bad_ofs
    $error("almost offset out of range");
  end

  wire        ftm = bus.fall_through_mode;
  bfmr_size_e size;
  assign size = bus.port_b_size;

  // port decode; a write is select high on port a, low on port b
  wire a_sel    = !bus.port_a_chip_select_n;
  wire b_sel    = !bus.port_b_chip_select_n;
  wire a_q_wr   = a_sel && bus.port_a_write_read_sel && !bus.port_a_mailbox_sel;
  wire a_q_rd   = a_sel && !bus.port_a_write_read_sel && !bus.port_a_mailbox_sel;
  wire a_mb_wr  = a_sel && bus.port_a_write_read_sel && bus.port_a_mailbox_sel;
  wire a_mb_rd  = a_sel && !bus.port_a_write_read_sel && bus.port_a_mailbox_sel;
  wire b_q_rd   = b_sel && bus.port_b_write_read_sel && !bus.port_b_mailbox_sel;
  wire b_q_wr   = b_sel && !bus.port_b_write_read_sel && !bus.port_b_mailbox_sel;
  wire b_mb_rd  = b_sel && bus.port_b_write_read_sel && bus.port_b_mailbox_sel;
  wire b_mb_wr  = b_sel && !bus.port_b_write_read_sel && bus.port_b_mailbox_sel;

  // per-queue handshakes: index 0 is a-to-b, index 1 is b-to-a
  wire [1:0]         emp_n;
  wire [1:0]         full_n;
  wire [1:0]         ae_n;
  wire [1:0]         af_n;
  wire [1:0]         push;
  wire [1:0]         pop;
  wire [1:0]         peek;
  wire [1:0]         retx;
  wire [BFMR_DW-1:0] wd [2];
  wire [BFMR_DW-1:0] qd [2];

  // port b lane tracking
  logic [1:0]         rl_r;
  logic [1:0]         shown_r;
  logic [1:0]         wl_r;
  logic [BFMR_DW-1:0] asm_r;

  wire        b_rd_ok   = b_q_rd && emp_n[0];
  wire        b_rd_last = b_rd_ok && bfmr_lane_last(size, rl_r);
  wire        b_wr_ok   = b_q_wr && full_n[1];
  wire        b_wr_last = b_wr_ok && bfmr_lane_last(size, wl_r);
  wire [35:0] b_lane_in = (bus.port_b_wdata & bfmr_lane_mask(size)) << bfmr_lane_shift(size, wl_r);
  wire [35:0] b_wr_word = asm_r | b_lane_in;
  wire [1:0]  b_out_lane = ftm ? rl_r : shown_r;

  assign push[0] = a_q_wr && full_n[0];
  assign wd[0]   = bus.port_a_wdata;
  assign pop[0]  = b_rd_last;
  assign peek[0] = b_rd_ok;
  assign retx[0] = bus.port_b_retransmit;
  assign push[1] = b_wr_last;
  assign wd[1]   = b_wr_word;
  assign pop[1]  = a_q_rd && emp_n[1];
  assign peek[1] = pop[1];
  assign retx[1] = bus.port_a_retransmit;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rl_r    <= 2'h0;
      shown_r <= 2'h0;
      wl_r    <= 2'h0;
      asm_r   <= '0;
    end else begin
      if (b_rd_ok) begin
        rl_r    <= b_rd_last ? 2'h0 : rl_r + 2'h1;
        shown_r <= rl_r;
      end
      if (b_wr_ok) begin
        wl_r  <= b_wr_last ? 2'h0 : wl_r + 2'h1;
        asm_r <= b_wr_last ? '0 : b_wr_word;
      end
    end
  end

  for (genvar q = 0; q < 2; q++) begin : g_q
    logic [BFMR_DW-1:0] mem [DEPTH];
    logic [AW-1:0]      wp_r;
    logic [AW-1:0]      rp_r;
    logic [CW-1:0]      cnt_r;
    logic [CW-1:0]      cnt_nxt;
    logic [CW-1:0]      tot_nxt;
    logic               ov_r;
    logic               ov_nxt;
    logic               emp_n_r;
    logic               emp_n_nxt;
    logic               full_n_r;
    logic               ae_n_r;
    logic               af_n_r;
    logic [BFMR_DW-1:0] dq_r;

    // fall-through keeps the output register stocked while memory holds data
    wire adv = !retx[q] && (ftm ? (cnt_r != '0 && (!ov_r || pop[q])) : pop[q]);
    wire [CW-1:0] push_c = {{AW{1'b0}}, push[q]};
    wire [CW-1:0] adv_c  = {{AW{1'b0}}, adv};

    always_comb begin
      if (retx[q]) begin
        cnt_nxt = {1'b0, wp_r} + push_c;
        ov_nxt  = 1'b0;
      end else begin
        cnt_nxt = cnt_r + push_c - adv_c;
        ov_nxt  = ftm && (adv || (ov_r && !pop[q]));
      end
      tot_nxt   = cnt_nxt + {{AW{1'b0}}, ov_nxt};
      // flag drops for one cycle during setup, rising again ends it
      emp_n_nxt = ftm ? ov_nxt : (cnt_nxt != '0 && !retx[q]);
    end

    // no reset on storage; pointers guard every read
    always_ff @(posedge ref_clk_i) begin
      if (push[q]) begin
        mem[wp_r] <= wd[q];
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        wp_r     <= '0;
        rp_r     <= '0;
        cnt_r    <= '0;
        ov_r     <= 1'b0;
        dq_r     <= '0;
        emp_n_r  <= 1'b0;
        full_n_r <= 1'b1;
        ae_n_r   <= 1'b0;
        af_n_r   <= 1'b1;
      end else begin
        if (push[q]) begin
          wp_r <= wp_r + 1'b1;
        end
        if (retx[q]) begin
          rp_r <= '0;
        end else if (adv) begin
          rp_r <= rp_r + 1'b1;
        end
        if (adv || (!ftm && peek[q])) begin
          dq_r <= mem[rp_r];
        end
        cnt_r    <= cnt_nxt;
        ov_r     <= ov_nxt;
        emp_n_r  <= emp_n_nxt;
        full_n_r <= cnt_nxt < DEPTH_C;
        ae_n_r   <= tot_nxt > AE_C;
        af_n_r   <= tot_nxt < (ftm ? AF_FT_C : AF_STD_C);
      end
    end

    assign emp_n[q]  = emp_n_r;
    assign full_n[q] = full_n_r;
    assign ae_n[q]   = ae_n_r;
    assign af_n[q]   = af_n_r;
    assign qd[q]     = dq_r;
  end

  // mailboxes keep only the lanes that port b can carry
  logic [35:0] ab_mail_r;
  logic [35:0] ba_mail_r;
  logic        ab_flag_n_r;
  logic        ba_flag_n_r;
  wire         ab_put = a_mb_wr && ab_flag_n_r;
  wire         ba_put = b_mb_wr && ba_flag_n_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ab_mail_r   <= '0;
      ba_mail_r   <= '0;
      ab_flag_n_r <= 1'b1;
      ba_flag_n_r <= 1'b1;
    end else begin
      if (ab_put) begin
        ab_mail_r <= bus.port_a_wdata & bfmr_lane_mask(size);
      end
      if (ba_put) begin
        ba_mail_r <= bus.port_b_wdata & bfmr_lane_mask(size);
      end
      // new mail beats a read in the same cycle
      ab_flag_n_r <= ab_put ? 1'b0 : (b_mb_rd ? 1'b1 : ab_flag_n_r);
      ba_flag_n_r <= ba_put ? 1'b0 : (a_mb_rd ? 1'b1 : ba_flag_n_r);
    end
  end

  // unused high lanes read as zero rather than stale data
  assign bus.port_b_rdata = (qd[0] >> bfmr_lane_shift(size, b_out_lane)) & bfmr_lane_mask(size);
  assign bus.port_a_rdata          = qd[1];
  assign bus.port_a_mail_rdata     = ba_mail_r;
  assign bus.port_b_mail_rdata     = ab_mail_r;
  assign bus.a_to_b_mail_flag_n    = ab_flag_n_r;
  assign bus.b_to_a_mail_flag_n    = ba_flag_n_r;
  assign bus.port_b_empty_n        = emp_n[0];
  assign bus.port_b_almost_empty_n = ae_n[0];
  assign bus.port_a_full_n         = full_n[0];
  assign bus.port_a_almost_full_n  = af_n[0];
  assign bus.port_a_empty_n        = emp_n[1];
  assign bus.port_a_almost_empty_n = ae_n[1];
  assign bus.port_b_full_n         = full_n[1];
  assign bus.port_b_almost_full_n  = af_n[1];
endmodule
`default_nettype wire

// >>> hw/bfmr_pkg.sv
// shared constants, lane helpers and types for the bidirectional queue pair
package bfmr_pkg;
  localparam int BFMR_DW         = 36;
  localparam int BFMR_DEPTH_16K  = 16384;
  localparam int BFMR_DEPTH_32K  = 32768;
  localparam int BFMR_DEPTH_64K  = 65536;
  localparam int BFMR_ALMOST_OFS = 8;
  localparam int BFMR_RETX_SLACK = 2;
  localparam logic [35:0] BFMR_MASK_LONG = 36'hf_ffff_ffff;
  localparam logic [35:0] BFMR_MASK_WORD = 36'h0_0003_ffff;
  localparam logic [35:0] BFMR_MASK_BYTE = 36'h0_0000_01ff;
  localparam logic [5:0]  BFMR_WORD_SHIFT = 6'h12;

  typedef enum logic [1:0] {
    BFMR_SIZE_LONG = 2'h0,
    BFMR_SIZE_WORD = 2'h1,
    BFMR_SIZE_BYTE = 2'h3
  } bfmr_size_e;

  function automatic logic [35:0] bfmr_lane_mask(input bfmr_size_e s);
    case (s)
      BFMR_SIZE_WORD: return BFMR_MASK_WORD;
      BFMR_SIZE_BYTE: return BFMR_MASK_BYTE;
      default:        return BFMR_MASK_LONG;
    endcase
  endfunction

  function automatic logic bfmr_lane_last(input bfmr_size_e s, input logic [1:0] l);
    case (s)
      BFMR_SIZE_WORD: return l[0];
      BFMR_SIZE_BYTE: return l == 2'h3;
      default:        return 1'b1;
    endcase
  endfunction

  // lane 0 is the low end of the long word
  function automatic logic [5:0] bfmr_lane_shift(input bfmr_size_e s, input logic [1:0] l);
    case (s)
      BFMR_SIZE_WORD: return l[0] ? BFMR_WORD_SHIFT : 6'h0;
      BFMR_SIZE_BYTE: return {1'b0, l, 3'h0} + {4'h0, l};
      default:        return 6'h0;
    endcase
  endfunction
endpackage

// >>> hw/bfmr_if.sv
// link between the queue-pair device and its two port hosts
`timescale 1ns/1ps
`default_nettype none
interface bfmr_if;
  import bfmr_pkg::*;
  logic        fall_through_mode;
  bfmr_size_e  port_b_size;
  logic        port_a_chip_select_n;
  logic        port_a_write_read_sel;
  logic        port_a_mailbox_sel;
  logic        port_a_retransmit;
  logic [35:0] port_a_wdata;
  logic [35:0] port_a_rdata;
  logic [35:0] port_a_mail_rdata;
  logic        port_a_empty_n;
  logic        port_a_almost_empty_n;
  logic        port_a_full_n;
  logic        port_a_almost_full_n;
  logic        port_b_chip_select_n;
  logic        port_b_write_read_sel;
  logic        port_b_mailbox_sel;
  logic        port_b_retransmit;
  logic [35:0] port_b_wdata;
  logic [35:0] port_b_rdata;
  logic [35:0] port_b_mail_rdata;
  logic        port_b_empty_n;
  logic        port_b_almost_empty_n;
  logic        port_b_full_n;
  logic        port_b_almost_full_n;
  logic        a_to_b_mail_flag_n;
  logic        b_to_a_mail_flag_n;

  modport dev (
    input  fall_through_mode, port_b_size,
    input  port_a_chip_select_n, port_a_write_read_sel, port_a_mailbox_sel,
    input  port_a_retransmit, port_a_wdata,
    input  port_b_chip_select_n, port_b_write_read_sel, port_b_mailbox_sel,
    input  port_b_retransmit, port_b_wdata,
    output port_a_rdata, port_a_mail_rdata, port_a_empty_n, port_a_almost_empty_n,
    output port_a_full_n, port_a_almost_full_n,
    output port_b_rdata, port_b_mail_rdata, port_b_empty_n, port_b_almost_empty_n,
    output port_b_full_n, port_b_almost_full_n,
    output a_to_b_mail_flag_n, b_to_a_mail_flag_n
  );
  modport host (
    output fall_through_mode, port_b_size,
    output port_a_chip_select_n, port_a_write_read_sel, port_a_mailbox_sel,
    output port_a_retransmit, port_a_wdata,
    output port_b_chip_select_n, port_b_write_read_sel, port_b_mailbox_sel,
    output port_b_retransmit, port_b_wdata,
    input  port_a_rdata, port_a_mail_rdata, port_a_empty_n, port_a_almost_empty_n,
    input  port_a_full_n, port_a_almost_full_n,
    input  port_b_rdata, port_b_mail_rdata, port_b_empty_n, port_b_almost_empty_n,
    input  port_b_full_n, port_b_almost_full_n,
    input  a_to_b_mail_flag_n, b_to_a_mail_flag_n
  );
endinterface
`default_nettype wire

// >>> hw/bfmr_host.sv
// host end: drives both ports from simple command requests
`timescale 1ns/1ps
`default_nettype none
module bfmr_host
  import bfmr_pkg::*;
#(
  parameter int DEPTH = BFMR_DEPTH_16K
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        fall_through_i,
  input  wire bfmr_size_e  b_size_i,
  input  wire logic        a_cmd_valid_i,
  input  wire logic        a_cmd_write_i,
  input  wire logic        a_cmd_mail_i,
  input  wire logic [35:0] a_wdata_i,
  input  wire logic        a_retx_req_i,
  output logic             a_cmd_ready_o,
  output logic             a_retx_ok_o,
  output logic [35:0]      a_rdata_o,
  output logic             a_rvalid_o,
  input  wire logic        b_cmd_valid_i,
  input  wire logic        b_cmd_write_i,
  input  wire logic        b_cmd_mail_i,
  input  wire logic [35:0] b_wdata_i,
  input  wire logic        b_retx_req_i,
  output logic             b_cmd_ready_o,
  output logic             b_retx_ok_o,
  output logic [35:0]      b_rdata_o,
  output logic             b_rvalid_o,
  bfmr_if.host             bus
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [CW-1:0] RETX_LIM_C = CW'(DEPTH - BFMR_RETX_SLACK);

  if (DEPTH <= BFMR_RETX_SLACK) begin : g_bad_depth
    $error("depth too small");
  end

  logic [CW-1:0] a_wcnt_r;
  logic [CW-1:0] b_wcnt_r;
  logic          a_pend_r;
  logic          b_pend_r;

  // a gate on readiness: queue reads wait for the flag that ends retransmit setup
  wire a_rdy_q = a_cmd_write_i ? bus.port_a_full_n : bus.port_a_empty_n;
  wire a_rdy_m = a_cmd_write_i ? bus.a_to_b_mail_flag_n : !bus.b_to_a_mail_flag_n;
  wire b_rdy_q = b_cmd_write_i ? bus.port_b_full_n : bus.port_b_empty_n;
  wire b_rdy_m = b_cmd_write_i ? bus.b_to_a_mail_flag_n : !bus.a_to_b_mail_flag_n;

  // port a retransmits the b-to-a queue, whose writes port b counts
  assign a_retx_ok_o   = b_wcnt_r <= RETX_LIM_C;
  assign b_retx_ok_o   = a_wcnt_r <= RETX_LIM_C;
  wire   a_retx        = a_retx_req_i && a_retx_ok_o;
  wire   b_retx        = b_retx_req_i && b_retx_ok_o;
  assign a_cmd_ready_o = !a_retx && (a_cmd_mail_i ? a_rdy_m : a_rdy_q);
  assign b_cmd_ready_o = !b_retx && (b_cmd_mail_i ? b_rdy_m : b_rdy_q);
  wire   a_go          = a_cmd_valid_i && a_cmd_ready_o;
  wire   b_go          = b_cmd_valid_i && b_cmd_ready_o;
  wire   a_qwr         = a_go && a_cmd_write_i && !a_cmd_mail_i;
  wire   b_qwr         = b_go && b_cmd_write_i && !b_cmd_mail_i;
  wire   a_rd          = a_go && !a_cmd_write_i;
  wire   b_rd          = b_go && !b_cmd_write_i;
  // standard-mode queue data lands one edge after the read
  wire   a_late        = !a_cmd_mail_i && !fall_through_i;
  wire   b_late        = !b_cmd_mail_i && !fall_through_i;

  assign bus.fall_through_mode     = fall_through_i;
  assign bus.port_b_size           = b_size_i;
  assign bus.port_a_chip_select_n  = !a_go;
  assign bus.port_a_write_read_sel = a_cmd_write_i;
  assign bus.port_a_mailbox_sel    = a_cmd_mail_i;
  assign bus.port_a_wdata          = a_wdata_i;
  assign bus.port_a_retransmit     = a_retx;
  assign bus.port_b_chip_select_n  = !b_go;
  assign bus.port_b_write_read_sel = !b_cmd_write_i;
  assign bus.port_b_mailbox_sel    = b_cmd_mail_i;
  assign bus.port_b_wdata          = b_wdata_i;
  assign bus.port_b_retransmit     = b_retx;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      a_wcnt_r   <= '0;
      b_wcnt_r   <= '0;
      a_pend_r   <= 1'b0;
      b_pend_r   <= 1'b0;
      a_rdata_o  <= '0;
      b_rdata_o  <= '0;
      a_rvalid_o <= 1'b0;
      b_rvalid_o <= 1'b0;
    end else begin
      // narrow lanes each count, so the limit errs on the safe side
      if (a_qwr && a_wcnt_r <= RETX_LIM_C) begin
        a_wcnt_r <= a_wcnt_r + 1'b1;
      end
      if (b_qwr && b_wcnt_r <= RETX_LIM_C) begin
        b_wcnt_r <= b_wcnt_r + 1'b1;
      end
      a_pend_r   <= a_rd && a_late;
      b_pend_r   <= b_rd && b_late;
      a_rvalid_o <= a_pend_r || (a_rd && !a_late);
      b_rvalid_o <= b_pend_r || (b_rd && !b_late);
      if (a_pend_r) begin
        a_rdata_o <= bus.port_a_rdata;
      end else if (a_rd && !a_late) begin
        a_rdata_o <= a_cmd_mail_i ? bus.port_a_mail_rdata : bus.port_a_rdata;
      end
      if (b_pend_r) begin
        b_rdata_o <= bus.port_b_rdata;
      end else if (b_rd && !b_late) begin
        b_rdata_o <= b_cmd_mail_i ? bus.port_b_mail_rdata : bus.port_b_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/bfmr_link_sva.sv
// assertion checker on the link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module bfmr_link_sva
  import bfmr_pkg::*;
#(
  parameter int DEPTH      = BFMR_DEPTH_16K,
  parameter int ALMOST_OFS = BFMR_ALMOST_OFS
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        fall_through_mode,
  input wire bfmr_size_e  port_b_size,
  input wire logic        port_a_chip_select_n,
  input wire logic        port_a_write_read_sel,
  input wire logic        port_a_mailbox_sel,
  input wire logic        port_a_retransmit,
  input wire logic [35:0] port_a_wdata,
  input wire logic [35:0] port_a_mail_rdata,
  input wire logic        port_a_empty_n,
  input wire logic        port_a_almost_empty_n,
  input wire logic        port_a_almost_full_n,
  input wire logic        port_b_chip_select_n,
  input wire logic        port_b_write_read_sel,
  input wire logic        port_b_mailbox_sel,
  input wire logic        port_b_retransmit,
  input wire logic [35:0] port_b_wdata,
  input wire logic [35:0] port_b_mail_rdata,
  input wire logic        port_b_empty_n,
  input wire logic        port_b_almost_empty_n,
  input wire logic        port_b_almost_full_n,
  input wire logic        a_to_b_mail_flag_n,
  input wire logic        b_to_a_mail_flag_n
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  wire logic [35:0] lane_m = (port_b_size == BFMR_SIZE_WORD) ? BFMR_MASK_WORD :
                             (port_b_size == BFMR_SIZE_BYTE) ? BFMR_MASK_BYTE : BFMR_MASK_LONG;
  wire logic a_sel = !port_a_chip_select_n;
  wire logic b_sel = !port_b_chip_select_n;
  wire logic a_wq  = a_sel && port_a_write_read_sel && !port_a_mailbox_sel;
  wire logic a_rq  = a_sel && !port_a_write_read_sel && !port_a_mailbox_sel;
  wire logic b_rq  = b_sel && port_b_write_read_sel && !port_b_mailbox_sel;
  wire logic b_wq  = b_sel && !port_b_write_read_sel && !port_b_mailbox_sel;
  // a write while mail is still waiting is dropped, so only count accepted ones
  wire logic a_wm  = a_sel && port_a_write_read_sel && port_a_mailbox_sel && a_to_b_mail_flag_n;
  wire logic b_wm  = b_sel && !port_b_write_read_sel && port_b_mailbox_sel && b_to_a_mail_flag_n;

  sequence s_setup_b;
    !port_b_empty_n ##1 port_b_empty_n;
  endsequence
  sequence s_setup_a;
    !port_a_empty_n ##[1:2] port_a_empty_n;
  endsequence

  property p_mail_ab;
    a_wm |=> port_b_mail_rdata == ($past(port_a_wdata) & lane_m);
  endproperty
  property p_mail_ba;
    b_wm |=> port_a_mail_rdata == ($past(port_b_wdata) & lane_m);
  endproperty
  property p_ae_b_rise;
    $rose(port_b_almost_empty_n) |-> $past(a_wq || port_b_retransmit);
  endproperty
  property p_ae_a_rise;
    $rose(port_a_almost_empty_n) |-> $past(b_wq || port_a_retransmit);
  endproperty
  property p_af_a_rise;
    $rose(port_a_almost_full_n) |-> $past(b_rq);
  endproperty
  property p_af_b_rise;
    $rose(port_b_almost_full_n) |-> $past(a_rq);
  endproperty
  property p_ae_b_fall;
    $fell(port_b_almost_empty_n) |-> $past(b_rq);
  endproperty
  property p_af_b_fall;
    $fell(port_b_almost_full_n) |-> $past(b_wq || port_a_retransmit);
  endproperty
  property p_retx_b;
    port_b_retransmit && !fall_through_mode |=> s_setup_b;
  endproperty
  property p_retx_a;
    port_a_retransmit && fall_through_mode |=> s_setup_a;
  endproperty

  a_mail_ab: assert property (p_mail_ab) else $error("a-to-b mail data wrong");
  a_mail_ba: assert property (p_mail_ba) else $error("b-to-a mail data wrong");
  a_ae_b_rise: assert property (p_ae_b_rise) else $error("b almost-empty rose alone");
  a_ae_a_rise: assert property (p_ae_a_rise) else $error("a almost-empty rose alone");
  a_af_a_rise: assert property (p_af_a_rise) else $error("a almost-full rose alone");
  a_af_b_rise: assert property (p_af_b_rise) else $error("b almost-full rose alone");
  a_ae_b_fall: assert property (p_ae_b_fall) else $error("b almost-empty fell alone");
  a_af_b_fall: assert property (p_af_b_fall) else $error("b almost-full fell alone");
  a_retx_b: assert property (p_retx_b) else $error("b retransmit setup wrong");
  a_retx_a: assert property (p_retx_a) else $error("a retransmit setup wrong");
endmodule
`default_nettype wire

// >>> tb/bfmr_tb_top.sv
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
`default_nettype none
module bfmr_tb_top;
  import bfmr_pkg::*;
  localparam int DEPTH = BFMR_DEPTH_16K;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        ft;
  bfmr_size_e  sz;
  logic        cv [2];
  logic        cw [2];
  logic        cm [2];
  logic        rx [2];
  logic [35:0] wd [2];
  logic        rdy [2];
  logic        ok [2];
  logic        rv [2];
  logic [35:0] rd [2];
  int          num_errors;
  int          check_count;

  bfmr_if bus ();
  bfmr_dev #(.DEPTH(DEPTH), .ALMOST_OFS(BFMR_ALMOST_OFS)) u_bfmr_dev (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus.dev));
  bfmr_host #(.DEPTH(DEPTH)) u_bfmr_host (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fall_through_i(ft), .b_size_i(sz),
    .a_cmd_valid_i(cv[0]), .a_cmd_write_i(cw[0]), .a_cmd_mail_i(cm[0]), .a_wdata_i(wd[0]),
    .a_retx_req_i(rx[0]), .a_cmd_ready_o(rdy[0]), .a_retx_ok_o(ok[0]), .a_rdata_o(rd[0]),
    .a_rvalid_o(rv[0]), .b_cmd_valid_i(cv[1]), .b_cmd_write_i(cw[1]), .b_cmd_mail_i(cm[1]),
    .b_wdata_i(wd[1]), .b_retx_req_i(rx[1]), .b_cmd_ready_o(rdy[1]), .b_retx_ok_o(ok[1]),
    .b_rdata_o(rd[1]), .b_rvalid_o(rv[1]), .bus(bus.host));
  bfmr_link_sva #(.DEPTH(DEPTH), .ALMOST_OFS(BFMR_ALMOST_OFS)) u_bfmr_link_sva (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fall_through_mode(bus.fall_through_mode),
    .port_b_size(bus.port_b_size), .port_a_chip_select_n(bus.port_a_chip_select_n),
    .port_a_write_read_sel(bus.port_a_write_read_sel),
    .port_a_mailbox_sel(bus.port_a_mailbox_sel), .port_a_retransmit(bus.port_a_retransmit),
    .port_a_wdata(bus.port_a_wdata), .port_a_mail_rdata(bus.port_a_mail_rdata),
    .port_a_empty_n(bus.port_a_empty_n), .port_a_almost_empty_n(bus.port_a_almost_empty_n),
    .port_a_almost_full_n(bus.port_a_almost_full_n),
    .port_b_chip_select_n(bus.port_b_chip_select_n),
    .port_b_write_read_sel(bus.port_b_write_read_sel),
    .port_b_mailbox_sel(bus.port_b_mailbox_sel), .port_b_retransmit(bus.port_b_retransmit),
    .port_b_wdata(bus.port_b_wdata), .port_b_mail_rdata(bus.port_b_mail_rdata),
    .port_b_empty_n(bus.port_b_empty_n), .port_b_almost_empty_n(bus.port_b_almost_empty_n),
    .port_b_almost_full_n(bus.port_b_almost_full_n),
    .a_to_b_mail_flag_n(bus.a_to_b_mail_flag_n), .b_to_a_mail_flag_n(bus.b_to_a_mail_flag_n));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic flag(input logic seen, input logic exp);
    chk({35'h0, seen}, {35'h0, exp});
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task rst(input logic f, input bfmr_size_e s);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    ft <= f;
    sz <= s;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask

  // the request is held until ready is seen, then dropped on the taking edge
  task cmd(input int p, input logic w, input logic m, input logic [35:0] d,
           output logic [35:0] r);
    int n;
    n = 0;
    r = 36'h0;
    @(posedge ref_clk_i);
    cv[p] <= 1'b1;
    cw[p] <= w;
    cm[p] <= m;
    wd[p] <= d;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (rdy[p] !== 1'b1 && n < 200);
    @(posedge ref_clk_i);
    cv[p] <= 1'b0;
    if (n >= 200) chk(36'h0, 36'h1);
    if (!w) begin
      n = 0;
      do begin
        @(negedge ref_clk_i);
        n++;
      end while (rv[p] !== 1'b1 && n < 20);
      r = rd[p];
    end
  endtask

  task retx(input int p);
    @(posedge ref_clk_i);
    rx[p] <= 1'b1;
    @(posedge ref_clk_i);
    rx[p] <= 1'b0;
  endtask

  task settle;
    repeat (2) @(negedge ref_clk_i);
  endtask

  task t_mail(input bfmr_size_e s, input logic [35:0] m);
    logic [35:0] r;
    rst(1'b0, s);
    cmd(0, 1'b1, 1'b1, 36'hf_ffff_ffff, r);
    cmd(1, 1'b0, 1'b1, 36'h0, r);
    chk(r, 36'hf_ffff_ffff & m);
    cmd(1, 1'b1, 1'b1, 36'hf_fffe_4321, r);
    cmd(0, 1'b0, 1'b1, 36'h0, r);
    chk(r, 36'hf_fffe_4321 & m);
    $display("test mailbox done");
  endtask

  task t_lanes;
    logic [35:0] r;
    rst(1'b0, BFMR_SIZE_WORD);
    cmd(0, 1'b1, 1'b0, 36'h9_8765_4321, r);
    cmd(1, 1'b0, 1'b0, 36'h0, r);
    chk(r, 36'h0_0001_4321);
    cmd(1, 1'b0, 1'b0, 36'h0, r);
    chk(r, 36'h0_0002_61d9);
    cmd(1, 1'b1, 1'b0, 36'h0_0001_1111, r);
    settle;
    flag(bus.port_a_empty_n, 1'b0);
    cmd(1, 1'b1, 1'b0, 36'h0_0002_2222, r);
    cmd(0, 1'b0, 1'b0, 36'h0, r);
    chk(r, 36'h8_8889_1111);
    $display("test lanes done");
  endtask

  // byte lanes leave port b low end first
  task t_bytes;
    logic [35:0] r;
    rst(1'b0, BFMR_SIZE_BYTE);
    cmd(0, 1'b1, 1'b0, 36'h9_8765_4321, r);
    for (int i = 0; i < 4; i++) begin
      cmd(1, 1'b0, 1'b0, 36'h0, r);
      chk(r, (36'h9_8765_4321 >> (9 * i)) & 36'h1ff);
    end
    $display("test bytes done");
  endtask

  // port b stays narrow so each flag only moves on the closing lane
  task t_flags;
    logic [35:0] r;
    rst(1'b0, BFMR_SIZE_WORD);
    for (int i = 0; i < 9; i++) cmd(0, 1'b1, 1'b0, 36'(i), r);
    settle;
    flag(bus.port_b_almost_empty_n, 1'b1);
    cmd(1, 1'b0, 1'b0, 36'h0, r);
    flag(bus.port_b_almost_empty_n, 1'b1);
    cmd(1, 1'b0, 1'b0, 36'h0, r);
    flag(bus.port_b_almost_empty_n, 1'b0);
    for (int i = 0; i < DEPTH - 16; i++) cmd(0, 1'b1, 1'b0, 36'(i), r);
    settle;
    flag(bus.port_a_almost_full_n, 1'b0);
    cmd(1, 1'b0, 1'b0, 36'h0, r);
    flag(bus.port_a_almost_full_n, 1'b0);
    cmd(1, 1'b0, 1'b0, 36'h0, r);
    flag(bus.port_a_almost_full_n, 1'b1);
    for (int i = 0; i < 17; i++) cmd(1, 1'b1, 1'b0, 36'(i), r);
    settle;
    flag(bus.port_a_almost_empty_n, 1'b0);
    cmd(1, 1'b1, 1'b0, 36'h0, r);
    settle;
    flag(bus.port_a_almost_empty_n, 1'b1);
    $display("test flags done");
  endtask

  task t_retx(input logic f);
    logic [35:0] r;
    int w;
    w = f ? 1 : 0;
    rst(f, BFMR_SIZE_LONG);
    for (int i = 0; i < 3; i++) cmd(w, 1'b1, 1'b0, 36'ha_0000_0000 + 36'(i), r);
    cmd(1 - w, 1'b0, 1'b0, 36'h0, r);
    cmd(1 - w, 1'b0, 1'b0, 36'h0, r);
    flag(ok[1 - w], 1'b1);
    retx(1 - w);
    cmd(1 - w, 1'b0, 1'b0, 36'h0, r);
    chk(r, 36'ha_0000_0000);
    $display("test retransmit done");
  endtask

  initial begin
    rst_n_i = 1'b0;
    ft = 1'b0;
    sz = BFMR_SIZE_LONG;
    num_errors = 0;
    check_count = 0;
    for (int k = 0; k < 2; k++) begin
      cv[k] = 1'b0;
      cw[k] = 1'b0;
      cm[k] = 1'b0;
      rx[k] = 1'b0;
      wd[k] = 36'h0;
    end
    t_mail(BFMR_SIZE_WORD, 36'h0_0003_ffff);
    t_mail(BFMR_SIZE_BYTE, 36'h0_0000_01ff);
    t_lanes;
    t_bytes;
    t_retx(1'b0);
    t_retx(1'b1);
    t_flags;
    end_sim;
  end

  // the fill loop dominates the run, about two cycles a word
  initial begin
    #600000;
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
